// [inc/sbs_pkg.sv]
// Function
// - every rising edge samples address, write data and all control inputs except output enable
// - address register loads on chip select low with either strobe low
// - a new address also loads its two low bits into the burst counter
// - both strobes low with chip select low: only the processor strobe counts, processor access
// - chip select high: processor strobe is ignored completely
// - high-byte write low: self-timed write of data 15..8 and parity bit 1
// - low-byte write low: self-timed write of data 7..0 and parity bit 0
// - processor strobe, chip select and byte write all low: write ignored
// - advance asserted steps the 2-bit wraparound burst counter
// - counter ordering is linear or interleaved, chosen per variant
// - advance ignored when a strobe is asserted with chip select
// - chip select high with controller strobe low deselects the device
// - interleaved order visits start xor 1, xor 2, xor 3
// - linear order adds one modulo four each step
// - a half floats in the cycle its byte write is sampled low
// - output enable acts asynchronously: low drives read data while selected, high floats
package sbs_pkg;
  localparam int ADDR_W   = 16;
  localparam int BURST_W  = 2;
  localparam int HALF_W   = 9;
  localparam int DATA_W   = 2 * HALF_W;
  localparam logic [ADDR_W-1:0]  ADDR_RST  = 16'h0000;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;

  // one half of the word: parity bit on top of its byte
  typedef struct packed {
    logic       parity;
    logic [7:0] data;
  } sbs_half_type;

  typedef struct packed {
    sbs_half_type hi;
    sbs_half_type lo;
  } sbs_word_type;

  typedef struct packed {
    logic proc_strobe_n;
    logic ctrl_strobe_n;
    logic chip_sel_n;
    logic hi_write_n;
    logic lo_write_n;
    logic step_n;
  } sbs_ctrl_type;
endpackage

// [hdl/sbs_core.sv]
`timescale 1ns/1ps
module sbs_core
  import sbs_pkg::*;
#(
  parameter bit INTERLEAVED = 1'b1
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rstn_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              processor_addr_strobe_n_i,
  input  wire logic              controller_addr_strobe_n_i,
  input  wire logic              chip_sel_n_i,
  input  wire logic              high_byte_write_n_i,
  input  wire logic              low_byte_write_n_i,
  input  wire logic              burst_step_n_i,
  input  wire logic              out_enable_n_i,
  input  wire logic [DATA_W-1:0] data_i,
  output logic      [DATA_W-1:0] data_o,
  output logic      [1:0]        data_oe_o,
  output logic                   selected_o
);
  sbs_word_type           mem [0:(1<<ADDR_W)-1];
  sbs_ctrl_type           ctrl_reg;
  sbs_word_type           din_reg;
  logic [ADDR_W-1:0]      ain_reg;
  logic [ADDR_W-1:0]      addr_reg, addr_next;
  logic [BURST_W-1:0]     burst_reg, burst_next;
  logic                   sel_reg, sel_next;
  sbs_word_type           rdata_reg;
  logic                   proc_hit, ctrl_hit, load, step, wr_hi, wr_lo;
  logic [ADDR_W-1:0]      array_addr, rd_addr, wr_addr;

  // pins sampled on every edge; memory and data register hold no reset value
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_reg <= '{default: 1'b1};
    end else begin
      ctrl_reg <= '{processor_addr_strobe_n_i, controller_addr_strobe_n_i, chip_sel_n_i,
                    high_byte_write_n_i, low_byte_write_n_i, burst_step_n_i};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    ain_reg <= addr_i;
    din_reg <= sbs_word_type'(data_i);
  end

  always_comb begin
    proc_hit = !ctrl_reg.proc_strobe_n && !ctrl_reg.chip_sel_n;
    ctrl_hit = !ctrl_reg.ctrl_strobe_n && !ctrl_reg.chip_sel_n && !proc_hit;
    load     = proc_hit || ctrl_hit;
    step     = !ctrl_reg.step_n && !load;
    wr_hi    = !ctrl_reg.hi_write_n && !proc_hit;
    wr_lo    = !ctrl_reg.lo_write_n && !proc_hit;
  end

  always_comb begin
    addr_next  = addr_reg;
    burst_next = burst_reg;
    sel_next   = sel_reg;
    if (load) begin
      addr_next  = ain_reg;
      burst_next = ain_reg[BURST_W-1:0];
      sel_next   = 1'b1;
    end else if (ctrl_reg.chip_sel_n && !ctrl_reg.ctrl_strobe_n) begin
      sel_next = 1'b0;
    end else if (step) begin
      if (INTERLEAVED) begin
        // walking start xor 1,2,3 is an xor of the count from start
        burst_next = addr_reg[BURST_W-1:0] ^
                     ((burst_reg ^ addr_reg[BURST_W-1:0]) + BURST_ONE);
      end else begin
        burst_next = burst_reg + BURST_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_reg  <= ADDR_RST;
      burst_reg <= BURST_RST;
      sel_reg   <= 1'b0;
    end else begin
      addr_reg  <= addr_next;
      burst_reg <= burst_next;
      sel_reg   <= sel_next;
    end
  end

  // array address follows the registers, so load and step take effect next cycle
  assign array_addr = {addr_reg[ADDR_W-1:BURST_W], burst_reg};

  // a write that comes with a load lands at the freshly loaded address
  assign wr_addr = load ? ain_reg : array_addr;
  // read port looks ahead so data follows the updated address without a bubble
  assign rd_addr = {addr_next[ADDR_W-1:BURST_W], burst_next};

  // sel_next is low on a deselect, so a deselected device starts no write
  always_ff @(posedge sys_clk_i) begin
    if (wr_hi && sel_next) begin
      mem[wr_addr].hi <= din_reg.hi;
    end
    if (wr_lo && sel_next) begin
      mem[wr_addr].lo <= din_reg.lo;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    rdata_reg <= mem[rd_addr];
  end

  assign data_o     = rdata_reg;
  assign selected_o = sel_reg;
  // enable is combinational on output enable so it acts without the clock
  assign data_oe_o[1] = !out_enable_n_i && sel_reg && ctrl_reg.hi_write_n;
  assign data_oe_o[0] = !out_enable_n_i && sel_reg && ctrl_reg.lo_write_n;
endmodule

// [tb/sbs_core_monitor.sv]
`timescale 1ns/1ps
module sbs_mon (
  input wire logic       sys_clk_i, rstn_i, chip_sel_n_i, out_enable_n_i, selected_o,
  input wire logic       processor_addr_strobe_n_i, controller_addr_strobe_n_i,
  input wire logic       high_byte_write_n_i, low_byte_write_n_i,
  input wire logic [1:0] data_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_quiet; (processor_addr_strobe_n_i && controller_addr_strobe_n_i)[*3]; endsequence
  property p_oe; out_enable_n_i |-> data_oe_o == 2'h0; endproperty
  a_oe: assert property (p_oe) else $error("driving while disabled");
  property p_hi; !high_byte_write_n_i |-> ##[1:2] !data_oe_o[1]; endproperty
  a_hi: assert property (p_hi) else $error("high half driven in write");
  property p_lo; !low_byte_write_n_i |-> ##[1:2] !data_oe_o[0]; endproperty
  a_lo: assert property (p_lo) else $error("low half driven in write");
  property p_ctrl;
    !chip_sel_n_i && !controller_addr_strobe_n_i |-> ##[1:2] selected_o;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("no select on load");
  property p_proc;
    !chip_sel_n_i && !processor_addr_strobe_n_i |-> ##[1:2] selected_o;
  endproperty
  a_proc: assert property (p_proc) else $error("no select on load");
  property p_desel;
    chip_sel_n_i && !controller_addr_strobe_n_i |-> ##[1:2] !selected_o;
  endproperty
  a_desel: assert property (p_desel) else $error("still selected");
  property p_rise;
    $rose(selected_o) |-> !$past(chip_sel_n_i) || !$past(chip_sel_n_i, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("selected without chip select");
  property p_hold; s_quiet |-> $stable(selected_o); endproperty
  a_hold: assert property (p_hold) else $error("select moved");
endmodule
bind sbs_core sbs_mon mon_u (.*);

// [tb/sbs_bus_host.sv]
`timescale 1ns/1ps
module sbs_bus_host import sbs_pkg::*; (
  input  wire logic [DATA_W-1:0] dev_i, host_i,
  input  wire logic [1:0]        oe_i,
  input  wire logic              drive_i,
  output logic      [DATA_W-1:0] bus_o
);
  logic [DATA_W-1:0] own_mask;
  // a released half shows the host word while writing, else the inverted word, so a stale value never passes
  assign own_mask = {{HALF_W{oe_i[1]}}, {HALF_W{oe_i[0]}}};
  assign bus_o = (dev_i & own_mask) | ((drive_i ? host_i : ~host_i) & ~own_mask);
endmodule

// [tb/sync_burst_sram_core_test.sv]
`timescale 1ns/1ps
module sync_burst_sram_core_test import sbs_pkg::*;;
  logic              sys_clk_i = 1'b0, rstn_i = 1'b0, oe_n = 1'b1, wr = 1'b0, sel = 1'b0, ld;
  logic              sel_q = 1'b0, sel_o, pw, wh, wl;
  sbs_ctrl_type      ctl = '1;
  logic [ADDR_W-1:0] addr = '0, ar = '0;
  logic [DATA_W-1:0] wd = '0, bus, dout, mem [int] = '{default: 'x};
  logic [DATA_W:0]   q [$] = '{19'h0, 19'h0}, e;
  logic [1:0]        cnt = 2'h0, doe;
  logic [5:0]        ops [8] = '{6'h3f, 6'h26, 6'h11, 6'h1e, 6'h2f, 6'h3e, 6'h39, 6'h07};
  logic [31:0]       r = 32'h00013218;
  int                num_errors = 0, samples_checked = 0, wcnt = 0, k;
  always #4 sys_clk_i = ~sys_clk_i;
  sbs_core dut_u (.sys_clk_i, .rstn_i, .addr_i(addr), .out_enable_n_i(oe_n), .data_i(bus),
    .processor_addr_strobe_n_i(ctl.proc_strobe_n),
    .controller_addr_strobe_n_i(ctl.ctrl_strobe_n), .chip_sel_n_i(ctl.chip_sel_n),
    .high_byte_write_n_i(ctl.hi_write_n), .low_byte_write_n_i(ctl.lo_write_n),
    .burst_step_n_i(ctl.step_n), .data_o(dout), .data_oe_o(doe), .selected_o(sel_o));
  sbs_bus_host host_u (.dev_i(dout), .oe_i(doe), .host_i(wd), .drive_i(wr), .bus_o(bus));
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // the design's output seen at an edge was launched one edge earlier, two after the pins
  always @(posedge sys_clk_i) if (rstn_i) begin
    e = q.pop_front();
    samples_checked += e[DATA_W] + 1;
    if (e[DATA_W] && dout !== e[DATA_W-1:0]) begin
      num_errors++;
      $display("CHECK FAILED %0t read data", $time);
    end
    if (sel_o !== sel_q) begin
      num_errors++;
      $display("CHECK FAILED %0t select flag", $time);
    end
    sel_q = sel;
    ld = !ctl.chip_sel_n && !(ctl.proc_strobe_n && ctl.ctrl_strobe_n);
    sel = ld || sel && !(ctl.chip_sel_n && !ctl.ctrl_strobe_n);
    if (ld) cnt = addr[1:0];
    if (ld) ar = addr;
    k = {ar[15:2], cnt};
    pw = !ctl.proc_strobe_n && !ctl.chip_sel_n;
    wh = sel && !ctl.hi_write_n && !pw;
    wl = sel && !ctl.lo_write_n && !pw;
    wcnt = (wh || wl) ? 3 : (wcnt > 0 ? wcnt - 1 : 0);
    if (wh) mem[k][17:9] = bus[17:9];
    if (wl) mem[k][8:0] = bus[8:0];
    if (!ld && !(ctl.chip_sel_n && !ctl.ctrl_strobe_n) && !ctl.step_n)
      cnt = ((cnt ^ ar[1:0]) + 2'h1) ^ ar[1:0];
    k = {ar[15:2], cnt};
    q.push_back({sel && wcnt == 0, mem[k]});
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  initial begin
    repeat (10) @(posedge sys_clk_i);
    #1 rstn_i = 1'b1;
    repeat (3000) begin
      @(posedge sys_clk_i);
      r = xs(r);
      #1 ctl = sbs_ctrl_type'(ops[r[2:0]]);
      wr = r[2:0] == 3'h6;
      if (wr) {ctl.ctrl_strobe_n, ctl.chip_sel_n} = r[8:7];
      if (wr && r[4:3] != 2'h3) {ctl.hi_write_n, ctl.lo_write_n} = r[4:3];
      {oe_n, addr, wd} = {wr | r[5], r[31:16], r[23:6]};
    end
    $display("random burst test done");
    summarize();
  end
  initial begin
    #40000 num_errors++;
    summarize();
  end
endmodule
